// >>> rtl/bar_device.sv
// Barometer sensor end: two-wire target, measurement sequencer and result store.
//
// Design decision made here: the result packet layout, pressure then temperature.
`timescale 1ns/1ps
`include "bar_consts.svh"

module bar_device #(
  parameter int          CONV_CYC = `BAR_CONV_CYC, // Full conversion time in cycles.
  parameter logic [23:0] P_TRIM   = 24'h00_0000,   // Pressure compensation offset.
  parameter logic [15:0] T_TRIM   = 16'h0000       // Temperature compensation offset.
) (
  input  wire logic        REF_CLK,    // 100 MHz clock.
  input  wire logic        RESET,      // Synchronous reset, active high.
  bar_i2c_if.dev           BUS,        // Two-wire link.
  input  wire logic [23:0] RAW_PRESS,  // Raw pressure from the converter.
  input  wire logic [15:0] RAW_TEMP,   // Raw temperature from the converter.
  output logic             SENSOR_PWR, // Sensing element supply switch.
  output logic             AWAKE       // High while a measurement runs.
);
  localparam int HALF = CONV_CYC / 2;

  bar_pkg::bar_bus_st_t  st_q;
  bar_pkg::bar_bus_st_t  after_q;
  bar_pkg::bar_meas_st_t ms_q;
  logic [2:0]            scl_s_q;
  logic [2:0]            sda_s_q;
  logic                  scl_f_q;
  logic                  sda_f_q;
  logic                  scl_p_q;
  logic                  sda_p_q;
  logic                  rise;
  logic                  fall;
  logic                  start;
  logic                  stop;
  logic [7:0]            sh_q;
  logic [3:0]            cnt_q;
  logic [7:0]            ptr_q;
  logic [39:0]           tx_q;
  logic [39:0]           pkt;
  logic                  sda_low_q;
  logic                  go_q;
  logic [`BAR_TMR_W-1:0] tmr_q;
  logic                  tmr_end;
  logic [23:0]           new_p_q;
  logic [15:0]           new_t_q;
  logic [23:0]           res_p_q;
  logic [15:0]           res_t_q;
  logic                  pend_q;
  logic                  store;

  // ----------------------------------------------------------------
  // Pin sampling
  // ----------------------------------------------------------------
  // Three stages per pin; a level is taken only when the last two agree.
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      scl_s_q <= 3'h7;
      sda_s_q <= 3'h7;
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[1:0], BUS.scl};
      sda_s_q <= {sda_s_q[1:0], BUS.sda};
      if (scl_s_q[2] == scl_s_q[1]) begin
        scl_f_q <= scl_s_q[2];
      end
      if (sda_s_q[2] == sda_s_q[1]) begin
        sda_f_q <= sda_s_q[2];
      end
      scl_p_q <= scl_f_q;
      sda_p_q <= sda_f_q;
    end
  end

  // Bus events; start and stop are data edges while the clock stays high.
  assign rise  = scl_f_q & ~scl_p_q;
  assign fall  = ~scl_f_q & scl_p_q;
  assign start = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q;
  assign stop  = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q;

  // Result packet, big-endian, pressure then temperature.
  // A pointer other than the result location reads as all ones.
  assign pkt = (ptr_q == `BAR_PTR_RESULT) ? {res_p_q, res_t_q} : '1;

  // ----------------------------------------------------------------
  // Target state machine
  // ----------------------------------------------------------------
  // Only acts on falling clock edges when driving, so data is stable at every rise.
  always_ff @(posedge REF_CLK) begin
    go_q <= 1'b0;
    if (RESET) begin
      st_q      <= bar_pkg::B_IDLE;
      after_q   <= bar_pkg::B_IDLE;
      sh_q      <= 8'h00;
      cnt_q     <= 4'h0;
      ptr_q     <= `BAR_PTR_RESULT;
      tx_q      <= '1;
      sda_low_q <= 1'b0;
    end else if (start) begin
      st_q      <= bar_pkg::B_ADDR;
      cnt_q     <= 4'h0;
      sda_low_q <= 1'b0;
    end else if (stop) begin
      st_q      <= bar_pkg::B_IDLE;
      sda_low_q <= 1'b0;
    end else begin
      unique case (st_q)
        bar_pkg::B_IDLE: begin
        end
        bar_pkg::B_ADDR, bar_pkg::B_WREG, bar_pkg::B_WDAT: begin
          if (rise) begin
            sh_q  <= {sh_q[6:0], sda_f_q};
            cnt_q <= cnt_q + 4'h1;
          end else if (fall && cnt_q == `BAR_BIT_ACK) begin
            sda_low_q <= 1'b1;
            st_q      <= bar_pkg::B_ACK;
            if (st_q == bar_pkg::B_ADDR) begin
              if (sh_q[7:1] != `BAR_DEV_ADDR) begin
                sda_low_q <= 1'b0;
                st_q      <= bar_pkg::B_IDLE;
              end else if (sh_q[0] == `BAR_RD_BIT) begin
                after_q <= bar_pkg::B_RD;
                tx_q    <= pkt;
              end else begin
                after_q <= bar_pkg::B_WREG;
              end
            end else if (st_q == bar_pkg::B_WREG) begin
              ptr_q   <= sh_q;
              after_q <= bar_pkg::B_WDAT;
            end else begin
              // Any other location or value is acknowledged and dropped.
              go_q    <= (ptr_q == `BAR_PTR_CMD) && (sh_q == `BAR_CMD_MEASURE);
              after_q <= bar_pkg::B_WDAT;
            end
          end
        end
        bar_pkg::B_ACK: begin
          if (fall) begin
            cnt_q     <= 4'h0;
            st_q      <= after_q;
            sda_low_q <= (after_q == bar_pkg::B_RD) ? ~tx_q[39] : 1'b0;
          end
        end
        bar_pkg::B_RD: begin
          if (fall) begin
            cnt_q <= cnt_q + 4'h1;
            tx_q  <= {tx_q[38:0], 1'b1};
            if (cnt_q == `BAR_BIT_LAST) begin
              sda_low_q <= 1'b0;
              st_q      <= bar_pkg::B_MACK;
            end else begin
              sda_low_q <= ~tx_q[38];
            end
          end
        end
        bar_pkg::B_MACK: begin
          // A high ninth bit is a not-acknowledge: stop sending.
          if (rise) begin
            st_q    <= sda_f_q ? bar_pkg::B_IDLE : bar_pkg::B_ACK;
            after_q <= bar_pkg::B_RD;
          end
        end
        default: begin
          st_q <= bar_pkg::B_IDLE;
        end
      endcase
    end
  end

  assign BUS.sda_d_o  = 1'b0;
  assign BUS.sda_d_oe = sda_low_q;

  // ----------------------------------------------------------------
  // Measurement sequencer
  // ----------------------------------------------------------------
  assign tmr_end = (tmr_q == `BAR_TMR_W'(HALF - 1));

  // Sleeps until asked; a request during a conversion is dropped, not queued.
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      ms_q    <= bar_pkg::M_SLEEP;
      tmr_q   <= '0;
      new_p_q <= 24'h00_0000;
      new_t_q <= 16'h0000;
    end else begin
      unique case (ms_q)
        bar_pkg::M_SLEEP: begin
          tmr_q <= '0;
          if (go_q) begin
            ms_q <= bar_pkg::M_PRES;
          end
        end
        bar_pkg::M_PRES: begin
          tmr_q <= tmr_end ? '0 : tmr_q + `BAR_TMR_W'(1);
          if (tmr_end) begin
            new_p_q <= RAW_PRESS + P_TRIM;
            ms_q    <= bar_pkg::M_TEMP;
          end
        end
        bar_pkg::M_TEMP: begin
          tmr_q <= tmr_end ? '0 : tmr_q + `BAR_TMR_W'(1);
          if (tmr_end) begin
            new_t_q <= RAW_TEMP + T_TRIM;
            ms_q    <= bar_pkg::M_SLEEP;
          end
        end
        default: begin
          ms_q <= bar_pkg::M_SLEEP;
        end
      endcase
    end
  end

  // Fresh results wait while a transfer is on the bus so a read never mixes two sets.
  assign store = pend_q && (st_q == bar_pkg::B_IDLE);

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= (ms_q == bar_pkg::M_TEMP && tmr_end) | (pend_q & ~store);
    end
  end

  // Results change only through a completed measurement, never through a fetch.
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      res_p_q <= 24'h00_0000;
      res_t_q <= 16'h0000;
    end else if (store) begin
      res_p_q <= new_p_q;
      res_t_q <= new_t_q;
    end
  end

  // Supply to the element is tied to the converting states only.
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      SENSOR_PWR <= 1'b0;
      AWAKE      <= 1'b0;
    end else begin
      SENSOR_PWR <= (ms_q == bar_pkg::M_PRES) || (ms_q == bar_pkg::M_TEMP);
      AWAKE      <= (ms_q != bar_pkg::M_SLEEP) || go_q;
    end
  end
endmodule

// >>> rtl/bar_consts.svh
// Constant definitions shared by both ends of the barometer link.
`ifndef BAR_CONSTS_SVH
`define BAR_CONSTS_SVH
`define BAR_DEV_ADDR    7'h6D
`define BAR_PTR_RESULT  8'h06
`define BAR_PTR_CMD     8'h30
`define BAR_CMD_MEASURE 8'h0A
`define BAR_RD_BIT      1'h1
`define BAR_WR_BIT      1'h0
`define BAR_PKT_BYTES   3'h5
`define BAR_BIT_ACK     4'h8
`define BAR_BIT_LAST    4'h7
`define BAR_CLK_NS      10
`define BAR_CONV_MS     5
`define BAR_CONV_CYC    (`BAR_CONV_MS * 1000000 / `BAR_CLK_NS)
`define BAR_SCL_NS      2500
`define BAR_QTR_CYC     ((`BAR_SCL_NS / 4 + `BAR_CLK_NS - 1) / `BAR_CLK_NS)
`define BAR_TMR_W       20
`define BAR_REG_CTRL    4'h0
`define BAR_REG_STATUS  4'h4
`define BAR_REG_PRESS   4'h8
`define BAR_REG_TEMP    4'hC
`define BAR_CTRL_MEAS   0
`define BAR_CTRL_FETCH  1
`define BAR_CTRL_CNT_LO 4
`define BAR_ST_BUSY     0
`define BAR_ST_NACK     1
`define BAR_ST_HOLD     2
`endif

// >>> rtl/bar_pkg.sv
// Types shared by both ends of the barometer link.
package bar_pkg;
  typedef enum logic [2:0] {
    B_IDLE = 3'h0, B_ADDR = 3'h1, B_ACK = 3'h2, B_WREG = 3'h3,
    B_WDAT = 3'h4, B_RD = 3'h5, B_MACK = 3'h6
  } bar_bus_st_t;
  typedef enum logic [1:0] {
    M_SLEEP = 2'h0, M_PRES = 2'h1, M_TEMP = 2'h2
  } bar_meas_st_t;
  typedef enum logic [2:0] {
    OP_START = 3'h0, OP_WR = 3'h1, OP_RD = 3'h2, OP_STOP = 3'h3, OP_DONE = 3'h4
  } bar_op_t;
  typedef struct packed {
    bar_op_t    op;
    logic [7:0] data;
  } bar_step_t;
endpackage

// >>> rtl/bar_i2c_if.sv
// Two-wire link between the barometer host controller and the sensor.
`timescale 1ns/1ps
interface bar_i2c_if;
  logic scl_o;
  logic scl_oe;
  logic sda_h_o;
  logic sda_h_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic scl;
  logic sda;
  // Open-drain wired-AND with pull-ups: a line is low while any driver pulls it low.
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~(sda_h_oe & ~sda_h_o) & ~(sda_d_oe & ~sda_d_o);
  modport host (output scl_o, output scl_oe, output sda_h_o, output sda_h_oe, input sda);
  modport dev  (input scl, input sda, output sda_d_o, output sda_d_oe);
endinterface

// >>> rtl/bar_host.sv
// Host end: Avalon-MM registers and a two-wire controller for the barometer.
`timescale 1ns/1ps
`include "bar_consts.svh"
module bar_host #(
  parameter int HOLD_CYC = `BAR_CONV_CYC, // Least spacing between requests.
  parameter int QTR_CYC  = `BAR_QTR_CYC   // Cycles per quarter bit on the link.
) (
  input  wire logic        REF_CLK,         // 100 MHz clock.
  input  wire logic        RESET,           // Synchronous reset, active high.
  bar_i2c_if.host          BUS,             // Two-wire link.
  input  wire logic [3:0]  AVS_ADDRESS,     // Byte address.
  input  wire logic        AVS_READ,        // Read request.
  input  wire logic        AVS_WRITE,       // Write request.
  input  wire logic [31:0] AVS_WRITEDATA,   // Write data.
  output logic      [31:0] AVS_READDATA,    // Read data.
  output logic             AVS_WAITREQUEST  // Stall until answered.
);
  localparam int QTR = QTR_CYC;

  bar_pkg::bar_step_t cur;
  bar_pkg::bar_op_t   op;
  logic [2:0]  sda_s_q;
  logic        sda_f_q;
  logic [7:0]  qcnt_q;
  logic        tick;
  logic        busy_q;
  logic        fetch_q;
  logic        nack_q;
  logic [2:0]  n_q;
  logic [3:0]  step_q;
  logic [1:0]  ph_q;
  logic [3:0]  bit_q;
  logic [7:0]  rx_q;
  logic [39:0] pkt_q;
  logic        scl_low_q;
  logic        sda_low_q;
  logic [31:0] hold_q;
  logic        ack_q;
  logic        wr_ctrl;
  logic [2:0]  n_in;
  logic [2:0]  ridx;

  // Byte sequence of a request or a fetch; a fetch reads n bytes after the reread.
  function automatic bar_pkg::bar_step_t seq(input logic f, input logic [3:0] s,
                                             input logic [2:0] n);
    seq = '{bar_pkg::OP_DONE, 8'h00};
    unique case (s)
      4'h0:    seq = '{bar_pkg::OP_START, 8'h00};
      4'h1:    seq = '{bar_pkg::OP_WR, {`BAR_DEV_ADDR, `BAR_WR_BIT}};
      4'h2:    seq = '{bar_pkg::OP_WR, f ? `BAR_PTR_RESULT : `BAR_PTR_CMD};
      4'h3: begin
        if (f) seq = '{bar_pkg::OP_START, 8'h00};
        else seq = '{bar_pkg::OP_WR, `BAR_CMD_MEASURE};
      end
      4'h4: begin
        if (f) seq = '{bar_pkg::OP_WR, {`BAR_DEV_ADDR, `BAR_RD_BIT}};
        else seq = '{bar_pkg::OP_STOP, 8'h00};
      end
      default: begin
        if (f && s < 4'h5 + {1'b0, n}) begin
          seq = '{bar_pkg::OP_RD, 8'h00};
        end else if (f && s == 4'h5 + {1'b0, n}) begin
          seq = '{bar_pkg::OP_STOP, 8'h00};
        end
      end
    endcase
  endfunction

  assign cur  = seq(fetch_q, step_q, n_q);
  assign op   = nack_q ? bar_pkg::OP_STOP : cur.op;
  assign tick = busy_q && (qcnt_q == 8'(QTR - 1));
  assign ridx = 3'(step_q - 4'h5);

  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------
  // Every access waits one cycle; this gives read data a full cycle to settle.
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_q;
  assign wr_ctrl = AVS_WRITE && ack_q && (AVS_ADDRESS == `BAR_REG_CTRL) && !busy_q;
  assign n_in = AVS_WRITEDATA[`BAR_CTRL_CNT_LO +: 3];

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      ack_q        <= 1'b0;
      AVS_READDATA <= 32'h0000_0000;
    end else begin
      ack_q <= (AVS_READ | AVS_WRITE) & ~ack_q;
      if (AVS_READ && !ack_q) begin
        unique case (AVS_ADDRESS)
          `BAR_REG_STATUS: AVS_READDATA <= {29'h0, hold_q != 32'h0, nack_q, busy_q};
          `BAR_REG_PRESS:  AVS_READDATA <= {8'h00, pkt_q[39:16]};
          `BAR_REG_TEMP:   AVS_READDATA <= {{16{pkt_q[15]}}, pkt_q[15:0]};
          default:         AVS_READDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  // A request is refused while the previous conversion may still run.
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      hold_q <= 32'h0000_0000;
    end else if (wr_ctrl && AVS_WRITEDATA[`BAR_CTRL_MEAS] && hold_q == 32'h0) begin
      hold_q <= 32'(HOLD_CYC);
    end else if (hold_q != 32'h0) begin
      hold_q <= hold_q - 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // Link engine
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      sda_s_q <= 3'h7;
      sda_f_q <= 1'b1;
    end else begin
      sda_s_q <= {sda_s_q[1:0], BUS.sda};
      if (sda_s_q[2] == sda_s_q[1]) begin
        sda_f_q <= sda_s_q[2];
      end
    end
  end

  // Each bit is four quarter periods: set data, raise clock, sample, lower clock.
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      busy_q <= 1'b0; fetch_q <= 1'b0; nack_q <= 1'b0; n_q <= 3'h0;
      step_q <= 4'h0; ph_q <= 2'h0; bit_q <= 4'h0; qcnt_q <= 8'h00;
      rx_q <= 8'h00; pkt_q <= 40'h00_0000_0000;
      scl_low_q <= 1'b0; sda_low_q <= 1'b0;
    end else if (!busy_q) begin
      qcnt_q <= 8'h00;
      if (wr_ctrl && (AVS_WRITEDATA[`BAR_CTRL_FETCH]
          || (AVS_WRITEDATA[`BAR_CTRL_MEAS] && hold_q == 32'h0))) begin
        busy_q  <= 1'b1;
        fetch_q <= AVS_WRITEDATA[`BAR_CTRL_FETCH];
        n_q     <= (n_in == 3'h0 || n_in > `BAR_PKT_BYTES) ? `BAR_PKT_BYTES : n_in;
        nack_q  <= 1'b0;
        step_q  <= 4'h0; ph_q <= 2'h0; bit_q <= 4'h0;
      end
    end else begin
      qcnt_q <= tick ? 8'h00 : qcnt_q + 8'h01;
      if (tick) begin
        ph_q <= ph_q + 2'h1;
        unique case (op)
          bar_pkg::OP_START: begin
            unique case (ph_q)
              2'h0: sda_low_q <= 1'b0;
              2'h1: scl_low_q <= 1'b0;
              2'h2: sda_low_q <= 1'b1;
              2'h3: begin scl_low_q <= 1'b1; step_q <= step_q + 4'h1; end
            endcase
          end
          bar_pkg::OP_WR, bar_pkg::OP_RD: begin
            unique case (ph_q)
              2'h0: begin
                if (bit_q == `BAR_BIT_ACK) begin
                  // Last wanted byte is not acknowledged so the target lets go.
                  sda_low_q <= (op == bar_pkg::OP_RD) && (step_q != 4'h4 + {1'b0, n_q});
                end else begin
                  sda_low_q <= (op == bar_pkg::OP_WR) && !cur.data[3'(`BAR_BIT_LAST - bit_q)];
                end
              end
              2'h1: scl_low_q <= 1'b0;
              2'h2: begin
                if (bit_q == `BAR_BIT_ACK && op == bar_pkg::OP_WR && sda_f_q) begin
                  nack_q <= 1'b1;
                end else if (bit_q != `BAR_BIT_ACK) begin
                  rx_q <= {rx_q[6:0], sda_f_q};
                end
              end
              2'h3: begin
                scl_low_q <= 1'b1;
                bit_q     <= (bit_q == `BAR_BIT_ACK) ? 4'h0 : bit_q + 4'h1;
                if (bit_q == `BAR_BIT_ACK) begin
                  step_q <= step_q + 4'h1;
                  if (op == bar_pkg::OP_RD) begin
                    pkt_q[6'd39 - {ridx, 3'h0} -: 8] <= rx_q;
                  end
                end
              end
            endcase
          end
          bar_pkg::OP_STOP: begin
            unique case (ph_q)
              2'h0: sda_low_q <= 1'b1;
              2'h1: scl_low_q <= 1'b0;
              2'h2: sda_low_q <= 1'b0;
              2'h3: busy_q <= 1'b0;
            endcase
          end
          default: busy_q <= 1'b0;
        endcase
      end
    end
  end

  assign BUS.scl_o    = 1'b0;
  assign BUS.scl_oe   = scl_low_q;
  assign BUS.sda_h_o  = 1'b0;
  assign BUS.sda_h_oe = sda_low_q;
endmodule

// >>> sim/bar_asserts.sv
// Concurrent checks on the barometer link and the sensor supply.
`timescale 1ns/1ps
module bar_asserts #(
  parameter int CONV_CYC = 2000 // Conversion time in cycles.
) (
  input wire logic REF_CLK,    // Clock.
  input wire logic RESET,      // Synchronous reset, active high.
  input wire logic scl,        // Resolved clock line.
  input wire logic sda_d_o,    // Device data level.
  input wire logic sda_d_oe,   // Device pulls data low.
  input wire logic SENSOR_PWR, // Sensing element supply.
  input wire logic AWAKE       // Measurement running.
);
  logic [15:0] pwr_cnt_q;
  logic [9:0]  ack_age_q;
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  // Cycles the supply has been on; cleared while off.
  always_ff @(posedge REF_CLK) begin
    if (RESET || !SENSOR_PWR) pwr_cnt_q <= 16'h0000;
    else pwr_cnt_q <= pwr_cnt_q + 16'h0001;
  end
  // Cycles since the device last pulled data low, saturating.
  always_ff @(posedge REF_CLK) begin
    if (RESET || sda_d_oe) ack_age_q <= 10'h000;
    else if (ack_age_q != 10'h3FF) ack_age_q <= ack_age_q + 10'h001;
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  pwr_in_wake_a: assert property (SENSOR_PWR |-> AWAKE)
    else $error("Sensor powered while asleep.");
  wake_to_pwr_a: assert property ($rose(AWAKE) |-> ##[1:3] SENSOR_PWR)
    else $error("Supply did not follow wake.");
  conv_time_a: assert property ($fell(SENSOR_PWR) |->
    (pwr_cnt_q + 100 >= CONV_CYC) && (pwr_cnt_q <= CONV_CYC + 100))
    else $error("Conversion length wrong.");
  wake_at_ack_a: assert property ($rose(AWAKE) |-> ack_age_q < 10'h12C)
    else $error("Woke without an acknowledged request.");
  pull_low_a: assert property ($rose(sda_d_oe) |-> !scl && !sda_d_o)
    else $error("Device pulled data while clock high.");
  data_on_low_a: assert property (scl && $past(scl) |-> $stable(sda_d_oe))
    else $error("Device changed data while clock high.");
  awake_hold_a: assert property ($rose(AWAKE) |=> AWAKE [*8])
    else $error("Wake dropped early.");
  sleep_off_a: assert property ($fell(AWAKE) |-> $fell(SENSOR_PWR))
    else $error("Slept with supply on.");
endmodule

// >>> sim/test_barometer_i2c_measure_readout.sv
// Self-checking bench joining the host controller and the sensor end.
`timescale 1ns/1ps
`include "bar_consts.svh"
module test_barometer_i2c_measure_readout;
  logic        ref_clk;
  logic        reset;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [23:0] raw_press;
  logic [15:0] raw_temp;
  logic        sensor_pwr;
  logic        awake;
  logic [23:0] p;
  logic [23:0] p_old;
  logic [15:0] t;
  logic [31:0] rp;
  logic [31:0] rt;
  localparam logic [23:0] P_TRIM_TB = 24'h00_0100; // Pressure trim under test.
  localparam logic [15:0] T_TRIM_TB = 16'h0010;    // Temperature trim under test.
  logic [31:0] pe;
  logic [31:0] po;
  int          fails;
  int          check_count;
  // ----------------------------------------------------------------
  // Design under test
  // ----------------------------------------------------------------
  bar_i2c_if bar_i2c_if_i ();
  bar_device #(.CONV_CYC(2000), .P_TRIM(P_TRIM_TB), .T_TRIM(T_TRIM_TB)) bar_device_i (
    .REF_CLK(ref_clk), .RESET(reset),
    .BUS(bar_i2c_if_i), .RAW_PRESS(raw_press), .RAW_TEMP(raw_temp),
    .SENSOR_PWR(sensor_pwr), .AWAKE(awake));
  // A shortened bit time keeps the whole run within its cycle budget.
  bar_host #(.HOLD_CYC(2000), .QTR_CYC(16)) bar_host_i (.REF_CLK(ref_clk), .RESET(reset),
    .BUS(bar_i2c_if_i), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest));
  bar_asserts #(.CONV_CYC(2000)) bar_asserts_i (.REF_CLK(ref_clk), .RESET(reset),
    .scl(bar_i2c_if_i.scl), .sda_d_o(bar_i2c_if_i.sda_d_o),
    .sda_d_oe(bar_i2c_if_i.sda_d_oe), .SENSOR_PWR(sensor_pwr), .AWAKE(awake));
  // Free-running 100 MHz clock.
  initial ref_clk = 1'b0;
  always #5 ref_clk = ~ref_clk;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // Compensation adds the trim; temperature is signed, so the register sign-extends it.
  function automatic logic [31:0] sext(input logic [15:0] v);
    logic [15:0] c;
    c = v + T_TRIM_TB;
    return {{16{c[15]}}, c};
  endfunction
  // Compensated pressure code as the register shows it.
  function automatic logic [31:0] comp_p(input logic [23:0] v);
    return {8'h00, 24'(v + P_TRIM_TB)};
  endfunction
  // One Avalon access; entered and left just after a rising edge.
  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) begin
      fails++;
      summarize();
    end
    @(posedge ref_clk);
  endtask
  // Polls one status bit until it clears, under a bound.
  task automatic wait_clear(input int b);
    logic [31:0] s;
    int n;
    n = 0;
    do begin
      av(1'b0, `BAR_REG_STATUS, 32'h0000_0000, s);
      n++;
    end while (s[b] !== 1'b0 && n < 2000);
    if (n >= 2000) begin
      fails++;
      summarize();
    end
  endtask
  // Requests one measurement and waits until the device sleeps again.
  task automatic measure(input logic [23:0] mp, input logic [15:0] mt);
    logic [31:0] q;
    int n;
    raw_press <= mp;
    raw_temp <= mt;
    wait_clear(`BAR_ST_HOLD);
    av(1'b1, `BAR_REG_CTRL, 32'h0000_0001, q);
    wait_clear(`BAR_ST_BUSY);
    check({31'h0000_0000, awake}, 32'h0000_0001);
    n = 0;
    while (awake !== 1'b0 && n < 5000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 5000) begin
      fails++;
      summarize();
    end
    check({31'h0000_0000, sensor_pwr | awake}, 32'h0000_0000);
  endtask
  // Reads n result bytes, then collects both result registers.
  task automatic fetch(input logic [2:0] n, output logic [31:0] fp, output logic [31:0] ft);
    logic [31:0] q;
    av(1'b1, `BAR_REG_CTRL, {25'h000_0000, n, 4'h2}, q);
    wait_clear(`BAR_ST_BUSY);
    av(1'b0, `BAR_REG_PRESS, 32'h0000_0000, fp);
    av(1'b0, `BAR_REG_TEMP, 32'h0000_0000, ft);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    fails = 0;
    check_count = 0;
    void'($urandom(32'h8024));
    reset = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    raw_press = 24'h12_3456;
    raw_temp = 16'h1234;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (300) @(posedge ref_clk);
    check({31'h0000_0000, awake | sensor_pwr}, 32'h0000_0000);
    fetch(3'h5, rp, rt);
    check(rp, 32'h0000_0000);
    check(rt, 32'h0000_0000);
    // Extreme codes first, then random ones; refetch with new raw input.
    for (int r = 0; r < 4; r++) begin
      p = (r == 0) ? 24'hFF_FFFF : 24'($urandom);
      t = (r == 0) ? 16'h8000 : (r == 1) ? 16'h7FFF : 16'($urandom);
      measure(p, t);
      fetch(3'h5, rp, rt);
      check(rp, comp_p(p));
      check(rt, sext(t));
      raw_press <= ~p;
      raw_temp <= ~t;
      fetch(3'h5, rp, rt);
      check(rp, comp_p(p));
      check(rt, sext(t));
    end
    // Pressure-only fetch leaves temperature as it was.
    p_old = p;
    p = 24'($urandom);
    measure(p, ~t);
    fetch(3'h3, rp, rt);
    check(rp, comp_p(p));
    check(rt, sext(t));
    // One byte read: only the top pressure byte is refreshed.
    p_old = p;
    p = ~p_old;
    measure(p, t);
    fetch(3'h1, rp, rt);
    pe = comp_p(p);
    po = comp_p(p_old);
    check(rp, {pe[31:16], po[15:0]});
    summarize();
  end
endmodule
